// file: rtl/ccr_top.sv
`timescale 1ns/1ps
`include "ccr_consts.svh"
module ccr_top #(
    parameter logic [6:0]  SLAVE_ADDR    = 7'h2a, // Arbitrary value
    parameter logic [3:0]  REVISION_CODE = 4'h3,  // Arbitrary value
    parameter logic [3:0]  VENDOR_CODE   = 4'h5,  // Arbitrary value
    parameter int unsigned BLOCK_COUNT   = `CCR_BLOCK_COUNT
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            reset,
    // Two-wire serial port, data pin is open drain
    input  wire logic            scl_in,
    input  wire logic            sda_in,
    output logic                 sda_out,
    output logic                 sda_oe,
    // Clock output controls
    output logic                 ref_clock_out_enable,
    output logic                 spread_cpu_clock_enable,
    output logic                 usb_clock_out_enable,
    output logic                 selectable_audio_out_enable,
    output logic                 fixed_audio_out_enable,
    output logic                 audio_frequency_select,
    output logic                 spread_pll_run,
    output logic                 fixed_audio_pll_run,
    output ccr_pkg::ccr_spread_t spread_depth,
    output logic                 spread_active
);
    generate
        if (BLOCK_COUNT < 1 || BLOCK_COUNT > 255) begin : g_bad_count
            $error("BLOCK_COUNT must be 1 to 255");
        end
    endgenerate

    localparam logic [7:0] COUNT_BYTE = BLOCK_COUNT[7:0];

    // ----------------------------------------------------------------
    // Pin synchronisers: a level counts once stages two and three agree
    // ----------------------------------------------------------------
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] pin_q;
    logic [1:0] prev_q;
    wire  [1:0] pin_d = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s1_q   <= `CCR_PIN_RESET;
            s2_q   <= `CCR_PIN_RESET;
            s3_q   <= `CCR_PIN_RESET;
            pin_q  <= `CCR_PIN_RESET;
            prev_q <= `CCR_PIN_RESET;
        end else begin
            s1_q   <= {scl_in, sda_in};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            pin_q  <= pin_d;
            prev_q <= pin_q;
        end
    end

    wire scl       = pin_q[1];
    wire sda       = pin_q[0];
    wire scl_rise  = scl && !prev_q[1];
    wire scl_fall  = !scl && prev_q[1];
    wire start_det = scl && prev_q[1] && prev_q[0] && !sda;
    wire stop_det  = scl && prev_q[1] && !prev_q[0] && sda;

    // ----------------------------------------------------------------
    // Serial engine state
    // ----------------------------------------------------------------
    ccr_pkg::ccr_state_t st_q, st_d;
    ccr_pkg::ccr_role_t  role_q, role_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] count_q, count_d;
    logic [1:0] ptr_q, ptr_d;
    logic       rw_q, rw_d;
    logic       block_q, block_d;
    logic       drive_q, drive_d;
    logic       got8_q, got8_d;
    logic       ack_q, ack_d;

    ccr_reg_if regs_bus ();

    // ----------------------------------------------------------------
    // Byte decode
    // ----------------------------------------------------------------
    wire rx_end    = (st_q == ccr_pkg::ST_RX) && got8_q && scl_fall;
    wire addr_hit  = (shift_q[7:1] == SLAVE_ADDR);
    wire cmd_block = (shift_q == `CCR_CMD_BLOCK);
    wire cmd_byte  = ((shift_q & ~`CCR_CMD_OFS_MASK) == `CCR_CMD_BYTE);
    wire in_cmd    = (role_q == ccr_pkg::R_CMD);
    wire in_data   = (role_q == ccr_pkg::R_DATA);
    wire blk_room  = !block_q || (count_q != 8'h00);
    wire accept    = (role_q == ccr_pkg::R_ADDR) ? addr_hit :
                     in_cmd ? (cmd_block || cmd_byte) : 1'b1;
    // Block reads open with the byte count, then the registers
    wire [7:0] tx_byte = (role_q == ccr_pkg::R_COUNT) ? COUNT_BYTE : regs_bus.rd_data;

    assign regs_bus.wr_en   = rx_end && in_data && blk_room;
    assign regs_bus.offset  = ptr_q;
    assign regs_bus.wr_data = shift_q;

    // ----------------------------------------------------------------
    // Next state; start and stop override any bit position
    // ----------------------------------------------------------------
    always_comb begin
        st_d    = st_q;
        role_d  = role_q;
        bit_d   = bit_q;
        shift_d = shift_q;
        count_d = count_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        block_d = block_q;
        drive_d = drive_q;
        got8_d  = got8_q;
        ack_d   = ack_q;
        if (start_det) begin
            st_d    = ccr_pkg::ST_RX;
            role_d  = ccr_pkg::R_ADDR;
            bit_d   = 3'h0;
            got8_d  = 1'b0;
            drive_d = 1'b0;
        end else if (stop_det) begin
            st_d    = ccr_pkg::ST_IDLE;
            drive_d = 1'b0;
        end else begin
            case (st_q)
                ccr_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda};
                        bit_d   = bit_q + 3'h1;
                        got8_d  = (bit_q == 3'h7);
                    end else if (rx_end) begin
                        st_d    = ccr_pkg::ST_RX_ACK;
                        ack_d   = accept;
                        drive_d = accept;
                        case (role_q)
                            ccr_pkg::R_ADDR: begin
                                rw_d   = shift_q[0];
                                role_d = !shift_q[0] ? ccr_pkg::R_CMD :
                                         block_q ? ccr_pkg::R_COUNT : ccr_pkg::R_DATA;
                            end
                            ccr_pkg::R_CMD: begin
                                if (cmd_block) begin
                                    block_d = 1'b1;
                                    ptr_d   = `CCR_OFS_ID;
                                    role_d  = ccr_pkg::R_COUNT;
                                end else if (cmd_byte) begin
                                    block_d = 1'b0;
                                    ptr_d   = shift_q[1:0];
                                    role_d  = ccr_pkg::R_DATA;
                                end
                            end
                            ccr_pkg::R_COUNT: begin
                                count_d = shift_q;
                                role_d  = ccr_pkg::R_DATA;
                            end
                            default: begin
                                if (blk_room) begin
                                    ptr_d = ptr_q + 2'h1;
                                end
                                if (block_q && blk_room) begin
                                    count_d = count_q - 8'h01;
                                end
                            end
                        endcase
                    end
                end
                ccr_pkg::ST_RX_ACK: begin
                    if (scl_fall) begin
                        bit_d  = 3'h0;
                        got8_d = 1'b0;
                        if (!ack_q) begin
                            st_d    = ccr_pkg::ST_IDLE;
                            drive_d = 1'b0;
                        end else if (rw_q) begin
                            st_d    = ccr_pkg::ST_TX;
                            shift_d = tx_byte;
                            drive_d = !tx_byte[7];
                        end else begin
                            st_d    = ccr_pkg::ST_RX;
                            drive_d = 1'b0;
                        end
                    end
                end
                ccr_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_q == 3'h7) begin
                            st_d    = ccr_pkg::ST_TX_ACK;
                            drive_d = 1'b0;
                            bit_d   = 3'h0;
                            if (role_q == ccr_pkg::R_COUNT) begin
                                role_d = ccr_pkg::R_DATA;
                            end else begin
                                ptr_d = ptr_q + 2'h1;
                            end
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            bit_d   = bit_q + 3'h1;
                            drive_d = !shift_q[6];
                        end
                    end
                end
                ccr_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        ack_d = !sda;
                    end else if (scl_fall) begin
                        if (ack_q) begin
                            st_d    = ccr_pkg::ST_TX;
                            shift_d = tx_byte;
                            drive_d = !tx_byte[7];
                        end else begin
                            st_d = ccr_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_q    <= ccr_pkg::ST_IDLE;
            role_q  <= ccr_pkg::R_ADDR;
            bit_q   <= 3'h0;
            shift_q <= 8'h00;
            count_q <= 8'h00;
            ptr_q   <= `CCR_OFS_ID;
            rw_q    <= 1'b0;
            block_q <= 1'b0;
            drive_q <= 1'b0;
            got8_q  <= 1'b0;
            ack_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            role_q  <= role_d;
            bit_q   <= bit_d;
            shift_q <= shift_d;
            count_q <= count_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            block_q <= block_d;
            drive_q <= drive_d;
            got8_q  <= got8_d;
            ack_q   <= ack_d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = drive_q;

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    ccr_regs #(
        .REVISION_CODE (REVISION_CODE),
        .VENDOR_CODE   (VENDOR_CODE)
    ) u_regs (
        .mclk                        (mclk),
        .reset                       (reset),
        .bus                         (regs_bus),
        .ref_clock_out_enable        (ref_clock_out_enable),
        .spread_cpu_clock_enable     (spread_cpu_clock_enable),
        .usb_clock_out_enable        (usb_clock_out_enable),
        .selectable_audio_out_enable (selectable_audio_out_enable),
        .fixed_audio_out_enable      (fixed_audio_out_enable),
        .audio_frequency_select      (audio_frequency_select),
        .spread_pll_run              (spread_pll_run),
        .fixed_audio_pll_run         (fixed_audio_pll_run),
        .spread_depth                (spread_depth),
        .spread_active               (spread_active)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_byte_cmd_offset: assert property (rx_end && in_cmd && cmd_byte |=>
        ptr_q == $past(shift_q[1:0]) && !block_q && in_data)
        else $error("byte command did not select its offset");
    a_block_cmd_start: assert property (rx_end && in_cmd && cmd_block |=>
        block_q && ptr_q == `CCR_OFS_ID && role_q == ccr_pkg::R_COUNT)
        else $error("block command did not start at offset zero");
    a_block_count_tx: assert property (st_q == ccr_pkg::ST_RX_ACK && scl_fall && ack_q &&
        rw_q && role_q == ccr_pkg::R_COUNT |=> st_q == ccr_pkg::ST_TX && shift_q == COUNT_BYTE)
        else $error("block read did not open with byte count");

    c_byte_write: cover property (regs_bus.wr_en && !block_q);
    c_block_write: cover property (regs_bus.wr_en && block_q);
    c_read_byte: cover property (st_q == ccr_pkg::ST_TX ##1 st_q == ccr_pkg::ST_TX_ACK);

endmodule : ccr_top

// file: common/ccr_consts.svh
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CCR_OFS_ID        2'h0
`define CCR_OFS_CTL       2'h1
`define CCR_OFS_SPREAD    2'h2

// ----------------------------------------------------------------
// Power-up values
// ----------------------------------------------------------------
`define CCR_CTL_RESET     8'hf7
`define CCR_SPREAD_RESET  8'h02
`define CCR_PIN_RESET     2'h3

// ----------------------------------------------------------------
// Output enable control fields
// ----------------------------------------------------------------
`define CCR_BIT_REF       7
`define CCR_BIT_CPU       6
`define CCR_BIT_USB       5
`define CCR_BIT_SELAUD    4
`define CCR_BIT_FIXAUD    3
`define CCR_BIT_RSV_HI    2
`define CCR_BIT_RSV_LO    1
`define CCR_BIT_AUDSEL    0

// ----------------------------------------------------------------
// Spread control fields and codes
// ----------------------------------------------------------------
`define CCR_SS_MSB        2
`define CCR_SS_LSB        0
`define CCR_SS_RSV_MSB    7
`define CCR_SS_RSV_LSB    3
`define CCR_SS_HALF       3'h1
`define CCR_SS_ONE        3'h2
`define CCR_SS_TWO        3'h4
`define CCR_SS_THREE      3'h6

// ----------------------------------------------------------------
// Serial command codes
// ----------------------------------------------------------------
`define CCR_CMD_BLOCK     8'h00
`define CCR_CMD_BYTE      8'h80
`define CCR_CMD_OFS_MASK  8'h03
`define CCR_BLOCK_COUNT   3

`endif

// file: common/ccr_pkg.sv
package ccr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX     = 3'b011,
        ST_TX_ACK = 3'b100
    } ccr_state_t;

    typedef enum logic [1:0] {
        R_ADDR  = 2'b00,
        R_CMD   = 2'b01,
        R_COUNT = 2'b10,
        R_DATA  = 2'b11
    } ccr_role_t;

    typedef enum logic [2:0] {
        SS_NONE  = 3'b000,
        SS_HALF  = 3'b001,
        SS_ONE   = 3'b010,
        SS_TWO   = 3'b011,
        SS_THREE = 3'b100
    } ccr_spread_t;

    function automatic ccr_spread_t ccr_decode_spread(input logic [2:0] code);
        case (code)
            3'h1:    return SS_HALF;
            3'h2:    return SS_ONE;
            3'h4:    return SS_TWO;
            3'h6:    return SS_THREE;
            default: return SS_NONE;
        endcase
    endfunction : ccr_decode_spread

endpackage : ccr_pkg

// file: common/ccr_reg_if.sv
`timescale 1ns/1ps
interface ccr_reg_if;
    logic       wr_en;
    logic [1:0] offset;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    modport engine (output wr_en, output offset, output wr_data, input rd_data);
    modport regs   (input wr_en, input offset, input wr_data, output rd_data);
endinterface : ccr_reg_if

// file: rtl/ccr_regs.sv
`timescale 1ns/1ps
`include "ccr_consts.svh"
module ccr_regs #(
    parameter logic [3:0] REVISION_CODE = 4'h3, // Arbitrary value
    parameter logic [3:0] VENDOR_CODE   = 4'h5  // Arbitrary value
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          reset,
    // Access from the serial engine
    ccr_reg_if.regs            bus,
    // Clock output controls
    output logic               ref_clock_out_enable,
    output logic               spread_cpu_clock_enable,
    output logic               usb_clock_out_enable,
    output logic               selectable_audio_out_enable,
    output logic               fixed_audio_out_enable,
    output logic               audio_frequency_select,
    output logic               spread_pll_run,
    output logic               fixed_audio_pll_run,
    output ccr_pkg::ccr_spread_t spread_depth,
    output logic               spread_active
);
    logic [7:0] ctl_q;
    logic [7:0] spread_q;
    wire        wr_ctl    = bus.wr_en && (bus.offset == `CCR_OFS_CTL);
    wire        wr_spread = bus.wr_en && (bus.offset == `CCR_OFS_SPREAD);
    wire [7:0]  id_byte   = {REVISION_CODE, VENDOR_CODE};

    // ----------------------------------------------------------------
    // Storage; the identification byte has no storage, so writes miss it
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctl_q    <= `CCR_CTL_RESET;
            spread_q <= `CCR_SPREAD_RESET;
        end else begin
            if (wr_ctl) begin
                ctl_q <= bus.wr_data;
            end
            if (wr_spread) begin
                spread_q <= bus.wr_data;
            end
        end
    end

    assign bus.rd_data = (bus.offset == `CCR_OFS_ID)     ? id_byte :
                         (bus.offset == `CCR_OFS_CTL)    ? ctl_q :
                         (bus.offset == `CCR_OFS_SPREAD) ? spread_q : 8'h00;

    // ----------------------------------------------------------------
    // Clock controls; a low enable holds the pad low
    // ----------------------------------------------------------------
    assign ref_clock_out_enable        = ctl_q[`CCR_BIT_REF];
    assign usb_clock_out_enable        = ctl_q[`CCR_BIT_USB];
    assign selectable_audio_out_enable = ctl_q[`CCR_BIT_SELAUD];
    assign spread_cpu_clock_enable     = ctl_q[`CCR_BIT_CPU];
    assign spread_pll_run              = ctl_q[`CCR_BIT_CPU];
    assign fixed_audio_out_enable      = ctl_q[`CCR_BIT_FIXAUD];
    assign fixed_audio_pll_run         = ctl_q[`CCR_BIT_FIXAUD];
    assign audio_frequency_select      = ctl_q[`CCR_BIT_AUDSEL];
    assign spread_depth  = ccr_pkg::ccr_decode_spread(spread_q[`CCR_SS_MSB:`CCR_SS_LSB]);
    assign spread_active = (spread_depth != ccr_pkg::SS_NONE);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_id_fixed: assert property (bus.wr_en && bus.offset == `CCR_OFS_ID |=>
        $stable(ctl_q) && $stable(spread_q))
        else $error("write to identification byte changed a register");
    a_enable_powerup: assert property ($past(reset) |-> ref_clock_out_enable &&
        usb_clock_out_enable && selectable_audio_out_enable)
        else $error("output enables not set after reset");
    a_cpu_pll_off: assert property (wr_ctl && !bus.wr_data[`CCR_BIT_CPU] |=>
        !spread_cpu_clock_enable && !spread_pll_run)
        else $error("spread clock or its pll still running");
    a_fixed_powerup: assert property ($past(reset) |->
        !fixed_audio_out_enable && !fixed_audio_pll_run)
        else $error("fixed audio clock not off after reset");
    a_sel_write: assert property (wr_ctl |=>
        audio_frequency_select == $past(bus.wr_data[`CCR_BIT_AUDSEL]))
        else $error("audio select did not follow write");
    a_spread_write: assert property (wr_spread |=>
        (spread_depth == ccr_pkg::SS_HALF) == ($past(bus.wr_data[2:0]) == `CCR_SS_HALF) &&
        (spread_depth == ccr_pkg::SS_ONE) == ($past(bus.wr_data[2:0]) == `CCR_SS_ONE) &&
        (spread_depth == ccr_pkg::SS_TWO) == ($past(bus.wr_data[2:0]) == `CCR_SS_TWO))
        else $error("spread depth did not follow write");
    a_spread_off: assert property (wr_spread |=>
        spread_active == ($past(bus.wr_data[2:0]) inside
            {`CCR_SS_HALF, `CCR_SS_ONE, `CCR_SS_TWO, `CCR_SS_THREE}) &&
        ($past(bus.wr_data[2:0]) == `CCR_SS_THREE) == (spread_depth == ccr_pkg::SS_THREE))
        else $error("spread active on a no-spread code");
    a_spread_powerup: assert property ($past(reset) |-> spread_depth == ccr_pkg::SS_ONE)
        else $error("spread not one percent after reset");
    a_rsv_powerup: assert property ($past(reset) |->
        ctl_q[`CCR_BIT_RSV_HI:`CCR_BIT_RSV_LO] == 2'b11 &&
        spread_q[`CCR_SS_RSV_MSB:`CCR_SS_RSV_LSB] == 5'h00)
        else $error("reserved bits wrong after reset");

    c_spread_three: cover property (wr_spread ##1 spread_depth == ccr_pkg::SS_THREE);

endmodule : ccr_regs

// file: sim/ccr_master.sv
`timescale 1ns/1ps
module ccr_master (
    // Clock
    input  wire logic mclk,
    // Two-wire pins
    input  wire logic sda_oe,
    input  wire logic sda_out,
    output logic      scl,
    output logic      sda
);
    logic sda_m = 1'b1;

    // Pull-up: a released wire reads high
    assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
    initial scl = 1'b1;

    // Phases of 12 cycles clear the design's pin filter
    task automatic hold();
        repeat (12) @(negedge mclk);
    endtask : hold

    task automatic bit_io(input logic b, output logic s);
        sda_m = b;
        hold();
        scl = 1'b1;
        hold();
        s = sda;
        scl = 1'b0;
    endtask : bit_io

    // Also serves as repeated start
    task automatic start();
        sda_m = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_m = 1'b0;
        hold();
        scl = 1'b0;
    endtask : start

    task automatic stop();
        sda_m = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_m = 1'b1;
        hold();
    endtask : stop

    // MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic k);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, k);
    endtask : xfer
endmodule : ccr_master

// file: sim/clock_output_control_regs_tb_top.sv
`timescale 1ns/1ps
module clock_output_control_regs_tb_top;
    logic                 mclk  = 1'b0;
    logic                 reset = 1'b1;
    logic                 scl, sda, sda_oe, sdo, k, act;
    logic [7:0]           q, ctl, ss;
    wire  [7:0]           en;
    logic [15:0]          r = 16'h66c4;
    int                   failures, check_count, cyc;
    ccr_pkg::ccr_spread_t depth;

    always #12.5 mclk = ~mclk;

    // Identity codes below are arbitrary
    ccr_top #(.SLAVE_ADDR(7'h2a), .REVISION_CODE(4'h6), .VENDOR_CODE(4'h9)) dut (
        .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sdo),
        .sda_oe(sda_oe), .ref_clock_out_enable(en[7]), .spread_cpu_clock_enable(en[6]),
        .usb_clock_out_enable(en[5]), .selectable_audio_out_enable(en[4]),
        .fixed_audio_out_enable(en[3]), .spread_pll_run(en[2]),
        .fixed_audio_pll_run(en[1]), .audio_frequency_select(en[0]),
        .spread_depth(depth), .spread_active(act));
    ccr_master m (.mclk(mclk), .sda_oe(sda_oe), .sda_out(sdo), .scl(scl), .sda(sda));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic send(input logic [7:0] b);
        m.xfer(b, 1'b1, q, k);
        chk({7'h0, k}, 8'h00);
    endtask : send

    task automatic wr(input logic [7:0] cmd, input logic [7:0] d[$]);
        m.start();
        send(8'h54);
        send(cmd);
        foreach (d[i]) send(d[i]);
        m.stop();
    endtask : wr

    // Last byte is refused by the master to end the read
    task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$]);
        m.start();
        send(8'h54);
        send(cmd);
        m.start();
        send(8'h55);
        foreach (e[i]) begin
            m.xfer(8'hff, i == e.size() - 1, q, k);
            chk(q, e[i]);
        end
        m.stop();
    endtask : rd

    task automatic outs();
        logic [2:0] d;
        d = ss[2:0] == 3'h1 ? 3'h1 : ss[2:0] == 3'h2 ? 3'h2 : ss[2:0] == 3'h4 ? 3'h3 :
            ss[2:0] == 3'h6 ? 3'h4 : 3'h0;
        chk(en, {ctl[7:3], ctl[6], ctl[3], ctl[0]});
        chk({4'h0, act, depth}, {4'h0, d != 3'h0, d});
    endtask : outs

    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        repeat (10) @(negedge mclk);
        ctl = 8'hf7;
        ss  = 8'h02;
        outs();
        rd(8'h80, '{8'h69, ctl, ss, 8'h00});
        // Command that is neither block nor byte must be refused
        m.start();
        send(8'h54);
        m.xfer(8'h40, 1'b1, q, k);
        chk({7'h0, k}, 8'h01);
        m.stop();
        rd(8'h81, '{ctl});
        $display("test power-up done");
        for (int i = 0; i < 3; i++) begin
            r   = lfsr(r);
            ctl = r[7:0] | 8'h06;
            wr(8'h81, '{ctl});
            outs();
            wr(8'h80, '{r[15:8]});
            rd(8'h80, '{8'h69});
        end
        $display("test control byte done");
        for (int c = 0; c < 8; c++) begin
            ss = {5'h0, c[2:0]};
            wr(8'h82, '{ss});
            outs();
        end
        $display("test spread codes done");
        r   = lfsr(r);
        ctl = r[15:8] | 8'h06;
        wr(8'h00, '{8'h02, r[7:0], ctl, 8'h05});
        outs();
        rd(8'h00, '{8'h03, 8'h69, ctl, ss, 8'h00});
        $display("test block transfer done");
        summarize();
    end
endmodule : clock_output_control_regs_tb_top
